/* File: include/fcb_pkg.sv */
// constants and types for the equalizer coefficient bank
// Notes on behaviour
// - non-centre tap coefficient bits 11:0 are used as signed two's complement
// - bits 15:12 of twelve-bit coefficient registers are reserved, read-write, reset zero
// - channel A sixth-tap register drives tap six of the channel A filter
// - register at index 0x425 drives tap seven of the channel A filter
// - register at index 0x427 drives tap eight of the channel A filter
// - register at index 0x429 drives tap nine, the last channel A tap
// - single-channel mode filters with the channel A set, same tap order
// - channel B first-tap register at index 0x448, read-write, resets to zero
// - channel B first-tap register drives tap one of the channel B filter, dual mode only
// - nine taps; centre coefficient eighteen bits, all others twelve bits
// - channel A sixth-tap register sits at index 0x423 and resets to zero
package fcb_pkg;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_A_TAP6 = 14'h0423;
   localparam logic [13:0] IDX_A_TAP7 = 14'h0425;
   localparam logic [13:0] IDX_A_TAP8 = 14'h0427;
   localparam logic [13:0] IDX_A_TAP9 = 14'h0429;
   localparam logic [13:0] IDX_B_TAP1 = 14'h0448;
   localparam logic [13:0] IDX_CTRL = 14'h0470;
   localparam logic [13:0] IDX_STATUS = 14'h0471;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;

   // field layout of a twelve-bit coefficient register
   localparam int COEF_MSB = 11;
   localparam int COEF_LSB = 0;
   localparam int RSVD_MSB = 15;
   localparam int RSVD_LSB = 12;
   localparam logic [REG_W-1:0] COEF_REG_RESET = 16'h0000;

   // control register: bit 0 selects single-channel mode
   localparam int CTRL_SINGLE_BIT = 0;
   localparam logic CTRL_SINGLE_RESET = 1'b0;
   // status register: bit 0 mode, bit 1 a output valid seen, bit 2 b output valid seen
   localparam int STAT_MODE_BIT = 0;
   localparam int STAT_A_SEEN_BIT = 1;
   localparam int STAT_B_SEEN_BIT = 2;

   // filter geometry
   localparam int TAPS = 9;
   localparam int CENTER_TAP = 4;
   localparam int SAMPLE_W = 12;
   localparam int COEF_W = 12;
   localparam int CENTER_W = 18;
   localparam int PROD_W = SAMPLE_W + CENTER_W;
   localparam int ACC_W = PROD_W + 4;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_A_TAP6 = 3'b001,
      SEL_A_TAP7 = 3'b010,
      SEL_A_TAP8 = 3'b011,
      SEL_A_TAP9 = 3'b100,
      SEL_B_TAP1 = 3'b101,
      SEL_CTRL = 3'b110,
      SEL_STATUS = 3'b111
   } fcb_sel_t;
endpackage

/* File: rtl/fcb_fir9.sv */
// nine-tap signed fir with registered output
`timescale 1ns/1ns
module fcb_fir9 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   input wire logic [fcb_pkg::SAMPLE_W-1:0] in_sample,
   input wire logic [fcb_pkg::TAPS-1:0][fcb_pkg::CENTER_W-1:0] coef,
   output logic [fcb_pkg::ACC_W-1:0] out_data,
   output logic out_valid
);
   typedef struct packed {
      logic [fcb_pkg::TAPS-2:0][fcb_pkg::SAMPLE_W-1:0] line;
      logic [fcb_pkg::ACC_W-1:0] acc;
      logic valid;
   } fcb_fir_state_t;

   fcb_fir_state_t state_ff;
   fcb_fir_state_t nxt_state;

   // tap 0 sees the incoming sample, tap k the sample k steps older
   always_comb begin
      logic signed [fcb_pkg::PROD_W-1:0] prod;
      logic signed [fcb_pkg::ACC_W-1:0] sum;
      logic [fcb_pkg::TAPS-1:0][fcb_pkg::SAMPLE_W-1:0] win;
      prod = '0;
      sum = '0;
      win = {state_ff.line, in_sample};
      nxt_state = state_ff;
      nxt_state.valid = in_valid;
      for (int k = 0; k < fcb_pkg::TAPS; k++) begin
         prod = $signed(win[k]) * $signed(coef[k]);
         sum = sum + fcb_pkg::ACC_W'(prod);
      end
      if (in_valid) begin
         nxt_state.line = win[fcb_pkg::TAPS-2:0];
         nxt_state.acc = sum;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign out_data = state_ff.acc;
   assign out_valid = state_ff.valid;
endmodule

/* File: rtl/fcb_coef_bank.sv */
// apb coefficient bank for the later channel a taps and first channel b tap
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module fcb_coef_bank (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fcb_pkg::ADDR_W-1:0] paddr,
   input wire logic [fcb_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [fcb_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // taps held by neighbouring register blocks
   input wire logic [fcb_pkg::COEF_W-1:0] chan_a_tap1_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_a_tap2_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_a_tap3_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_a_tap4_coeff,
   input wire logic [fcb_pkg::CENTER_W-1:0] chan_a_center_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap2_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap3_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap4_coeff,
   input wire logic [fcb_pkg::CENTER_W-1:0] chan_b_center_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap6_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap7_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap8_coeff,
   input wire logic [fcb_pkg::COEF_W-1:0] chan_b_tap9_coeff,
   // sample streams from the converter core
   input wire logic chan_a_in_valid,
   input wire logic [fcb_pkg::SAMPLE_W-1:0] chan_a_in_sample,
   input wire logic chan_b_in_valid,
   input wire logic [fcb_pkg::SAMPLE_W-1:0] chan_b_in_sample,
   // filtered streams
   output logic [fcb_pkg::ACC_W-1:0] chan_a_out_data,
   output logic chan_a_out_valid,
   output logic [fcb_pkg::ACC_W-1:0] chan_b_out_data,
   output logic chan_b_out_valid,
   output logic single_channel_mode
);
   typedef struct packed {
      logic [fcb_pkg::REG_W-1:0] a_tap6;
      logic [fcb_pkg::REG_W-1:0] a_tap7;
      logic [fcb_pkg::REG_W-1:0] a_tap8;
      logic [fcb_pkg::REG_W-1:0] a_tap9;
      logic [fcb_pkg::REG_W-1:0] b_tap1;
      logic single;
      logic a_seen;
      logic b_seen;
      logic [fcb_pkg::DATA_W-1:0] rdata;
      logic ready;
      logic err;
   } fcb_bank_state_t;

   fcb_bank_state_t state_ff;
   fcb_bank_state_t nxt_state;

   logic [fcb_pkg::TAPS-1:0][fcb_pkg::CENTER_W-1:0] coef_a;
   logic [fcb_pkg::TAPS-1:0][fcb_pkg::CENTER_W-1:0] coef_b;
   logic [fcb_pkg::ACC_W-1:0] fir_a_data;
   logic fir_a_valid;
   logic [fcb_pkg::ACC_W-1:0] fir_b_data;
   logic fir_b_valid;
   logic fir_b_in_valid;
   fcb_pkg::fcb_sel_t setup_sel;
   fcb_pkg::fcb_sel_t access_sel;
   logic setup_phase;
   logic write_commit;

   // word-aligned index decode, shared by the read and the write path
   function automatic fcb_pkg::fcb_sel_t fcb_decode(input logic [fcb_pkg::ADDR_W-1:0] addr);
      logic [13:0] idx;
      idx = addr[fcb_pkg::ADDR_W-1:2];
      if (addr[1:0] != 2'b00) begin
         fcb_decode = fcb_pkg::SEL_NONE;
      end else if (idx == fcb_pkg::IDX_A_TAP6) begin
         fcb_decode = fcb_pkg::SEL_A_TAP6;
      end else if (idx == fcb_pkg::IDX_A_TAP7) begin
         fcb_decode = fcb_pkg::SEL_A_TAP7;
      end else if (idx == fcb_pkg::IDX_A_TAP8) begin
         fcb_decode = fcb_pkg::SEL_A_TAP8;
      end else if (idx == fcb_pkg::IDX_A_TAP9) begin
         fcb_decode = fcb_pkg::SEL_A_TAP9;
      end else if (idx == fcb_pkg::IDX_B_TAP1) begin
         fcb_decode = fcb_pkg::SEL_B_TAP1;
      end else if (idx == fcb_pkg::IDX_CTRL) begin
         fcb_decode = fcb_pkg::SEL_CTRL;
      end else if (idx == fcb_pkg::IDX_STATUS) begin
         fcb_decode = fcb_pkg::SEL_STATUS;
      end else begin
         fcb_decode = fcb_pkg::SEL_NONE;
      end
   endfunction

   // merge a 16-bit register with the two low write lanes
   function automatic logic [fcb_pkg::REG_W-1:0] fcb_merge(
      input logic [fcb_pkg::REG_W-1:0] old_val,
      input logic [fcb_pkg::DATA_W-1:0] wdata,
      input logic [3:0] strb
   );
      logic [fcb_pkg::REG_W-1:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         res[15:8] = wdata[15:8];
      end
      fcb_merge = res;
   endfunction

   // sign-extend a twelve-bit tap to the centre tap width
   function automatic logic [fcb_pkg::CENTER_W-1:0] fcb_sext(
      input logic [fcb_pkg::COEF_W-1:0] c
   );
      fcb_sext = {{(fcb_pkg::CENTER_W - fcb_pkg::COEF_W){c[fcb_pkg::COEF_W-1]}}, c};
   endfunction

   assign setup_phase = psel && !penable;
   assign setup_sel = fcb_decode(paddr);
   assign access_sel = fcb_decode(paddr);
   // a write lands only at the edge where the master sees pready high
   assign write_commit = psel && penable && pwrite && state_ff.ready;

   // register file and apb answer; one wait-free access phase per transfer
   always_comb begin
      nxt_state = state_ff;
      nxt_state.ready = 1'b0;
      if (setup_phase) begin
         nxt_state.ready = 1'b1;
         nxt_state.err = (setup_sel == fcb_pkg::SEL_NONE);
         nxt_state.rdata = '0;
         if (!pwrite) begin
            case (setup_sel)
               fcb_pkg::SEL_A_TAP6: nxt_state.rdata = 32'(state_ff.a_tap6);
               fcb_pkg::SEL_A_TAP7: nxt_state.rdata = 32'(state_ff.a_tap7);
               fcb_pkg::SEL_A_TAP8: nxt_state.rdata = 32'(state_ff.a_tap8);
               fcb_pkg::SEL_A_TAP9: nxt_state.rdata = 32'(state_ff.a_tap9);
               fcb_pkg::SEL_B_TAP1: nxt_state.rdata = 32'(state_ff.b_tap1);
               fcb_pkg::SEL_CTRL: begin
                  nxt_state.rdata[fcb_pkg::CTRL_SINGLE_BIT] = state_ff.single;
               end
               fcb_pkg::SEL_STATUS: begin
                  nxt_state.rdata[fcb_pkg::STAT_MODE_BIT] = state_ff.single;
                  nxt_state.rdata[fcb_pkg::STAT_A_SEEN_BIT] = state_ff.a_seen;
                  nxt_state.rdata[fcb_pkg::STAT_B_SEEN_BIT] = state_ff.b_seen;
               end
               default: nxt_state.rdata = '0;
            endcase
         end
      end else begin
         // answer stands for the access cycle only, then read data drops to zero
         nxt_state.err = 1'b0;
         nxt_state.rdata = '0;
      end
      // output-seen flags are sticky; reading status does not clear them
      if (fir_a_valid) begin
         nxt_state.a_seen = 1'b1;
      end
      if (fir_b_valid) begin
         nxt_state.b_seen = 1'b1;
      end
      if (write_commit) begin
         // reserved bits 15:12 store whatever is written
         case (access_sel)
            fcb_pkg::SEL_A_TAP6: begin
               nxt_state.a_tap6 = fcb_merge(state_ff.a_tap6, pwdata, pstrb);
            end
            fcb_pkg::SEL_A_TAP7: begin
               nxt_state.a_tap7 = fcb_merge(state_ff.a_tap7, pwdata, pstrb);
            end
            fcb_pkg::SEL_A_TAP8: begin
               nxt_state.a_tap8 = fcb_merge(state_ff.a_tap8, pwdata, pstrb);
            end
            fcb_pkg::SEL_A_TAP9: begin
               nxt_state.a_tap9 = fcb_merge(state_ff.a_tap9, pwdata, pstrb);
            end
            fcb_pkg::SEL_B_TAP1: begin
               nxt_state.b_tap1 = fcb_merge(state_ff.b_tap1, pwdata, pstrb);
            end
            fcb_pkg::SEL_CTRL: begin
               if (pstrb[0]) begin
                  nxt_state.single = pwdata[fcb_pkg::CTRL_SINGLE_BIT];
               end
            end
            default: begin
               // status is read-only, unmapped writes are dropped
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff.a_tap6 <= fcb_pkg::COEF_REG_RESET;
         state_ff.a_tap7 <= fcb_pkg::COEF_REG_RESET;
         state_ff.a_tap8 <= fcb_pkg::COEF_REG_RESET;
         state_ff.a_tap9 <= fcb_pkg::COEF_REG_RESET;
         state_ff.b_tap1 <= fcb_pkg::COEF_REG_RESET;
         state_ff.single <= fcb_pkg::CTRL_SINGLE_RESET;
         state_ff.a_seen <= 1'b0;
         state_ff.b_seen <= 1'b0;
         state_ff.rdata <= '0;
         state_ff.ready <= 1'b0;
         state_ff.err <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // channel a tap set; the same set serves the single filter in single mode
   assign coef_a[0] = fcb_sext(chan_a_tap1_coeff);
   assign coef_a[1] = fcb_sext(chan_a_tap2_coeff);
   assign coef_a[2] = fcb_sext(chan_a_tap3_coeff);
   assign coef_a[3] = fcb_sext(chan_a_tap4_coeff);
   assign coef_a[fcb_pkg::CENTER_TAP] = chan_a_center_coeff;
   assign coef_a[5] = fcb_sext(state_ff.a_tap6[fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB]);
   assign coef_a[6] = fcb_sext(state_ff.a_tap7[fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB]);
   assign coef_a[7] = fcb_sext(state_ff.a_tap8[fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB]);
   assign coef_a[8] = fcb_sext(state_ff.a_tap9[fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB]);

   // channel b tap set
   assign coef_b[0] = fcb_sext(state_ff.b_tap1[fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB]);
   assign coef_b[1] = fcb_sext(chan_b_tap2_coeff);
   assign coef_b[2] = fcb_sext(chan_b_tap3_coeff);
   assign coef_b[3] = fcb_sext(chan_b_tap4_coeff);
   assign coef_b[fcb_pkg::CENTER_TAP] = chan_b_center_coeff;
   assign coef_b[5] = fcb_sext(chan_b_tap6_coeff);
   assign coef_b[6] = fcb_sext(chan_b_tap7_coeff);
   assign coef_b[7] = fcb_sext(chan_b_tap8_coeff);
   assign coef_b[8] = fcb_sext(chan_b_tap9_coeff);

   // channel b filter idles in single mode so its history stays frozen
   assign fir_b_in_valid = chan_b_in_valid && !state_ff.single;

   // the a filter carries the only stream in single mode
   fcb_fir9 u_fir_a (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(chan_a_in_valid),
      .in_sample(chan_a_in_sample),
      .coef(coef_a),
      .out_data(fir_a_data),
      .out_valid(fir_a_valid)
   );

   fcb_fir9 u_fir_b (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(fir_b_in_valid),
      .in_sample(chan_b_in_sample),
      .coef(coef_b),
      .out_data(fir_b_data),
      .out_valid(fir_b_valid)
   );

   assign prdata = state_ff.rdata;
   assign pready = state_ff.ready;
   assign pslverr = state_ff.err;
   assign chan_a_out_data = fir_a_data;
   assign chan_a_out_valid = fir_a_valid;
   assign chan_b_out_data = fir_b_data;
   assign chan_b_out_valid = fir_b_valid;
   assign single_channel_mode = state_ff.single;
endmodule

/* File: tb/fcb_coef_bank_properties.sv */
// concurrent checks on the coefficient bank ports
`timescale 1ns/1ns
module fcb_coef_bank_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fcb_pkg::ADDR_W-1:0] paddr,
   input wire logic [fcb_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [fcb_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chan_a_in_valid,
   input wire logic [fcb_pkg::ACC_W-1:0] chan_a_out_data,
   input wire logic chan_a_out_valid,
   input wire logic chan_b_in_valid,
   input wire logic chan_b_out_valid,
   input wire logic single_channel_mode
);
   default clocking cb_clk @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic ctrl_wr;
   // committed write to the mode control word, byte lane 0 only
   assign ctrl_wr = psel && penable && pwrite && pready && pstrb[0] &&
      paddr == {fcb_pkg::IDX_CTRL, 2'b00};
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   AST_HSHAKE: assert property (s_setup |=> s_answer)
      else $error("apb answer not a single cycle pulse");
   AST_ALIGN: assert property (s_setup ##0 paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access not refused");
   AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer malformed");
   AST_RDATA_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside a read access");
   AST_UPPER: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   AST_MODE_SET: assert property (ctrl_wr |=> single_channel_mode == $past(pwdata[0]))
      else $error("mode bit not taken from write");
   AST_MODE_HOLD: assert property (!ctrl_wr |=> $stable(single_channel_mode))
      else $error("mode changed without a write");
   AST_A_VALID: assert property (chan_a_in_valid |=> chan_a_out_valid)
      else $error("channel a output missing");
   AST_A_QUIET: assert property (!chan_a_in_valid |=> !chan_a_out_valid &&
      $stable(chan_a_out_data))
      else $error("channel a output without sample");
   AST_B_REFUSED: assert property (chan_b_in_valid && single_channel_mode
      |=> !chan_b_out_valid)
      else $error("channel b active in single mode");
   AST_B_VALID: assert property (chan_b_in_valid && !single_channel_mode
      |=> chan_b_out_valid)
      else $error("channel b output missing");
endmodule

bind fcb_coef_bank fcb_coef_bank_chk u_fcb_coef_bank_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .chan_a_in_valid,
   .chan_a_out_data, .chan_a_out_valid, .chan_b_in_valid, .chan_b_out_valid,
   .single_channel_mode);

/* File: tb/fcb_coef_bank_tb_top.sv */
// self-checking bench for the coefficient bank and its two filters
`timescale 1ns/1ns
module fcb_coef_bank_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic va_in = 1'b0;
   logic vb_in = 1'b0;
   logic [11:0] sa_in = 12'h0;
   logic [11:0] sb_in = 12'h0;
   logic [33:0] a_out;
   logic [33:0] b_out;
   logic a_ov;
   logic b_ov;
   logic mode;
   int ca [9] = '{5, -7, 11, -13, -90000, 300, -2048, 2047, -1};
   int cb [9] = '{-5, 3, 2, 1, 1000, -1, -2, -3, 4};
   longint ha [9] = '{default: 0};
   longint hb [9] = '{default: 0};
   longint pa = 0;
   longint pb = 0;
   logic pva = 1'b0;
   logic pvb = 1'b0;
   logic mode_m = 1'b0;
   logic [13:0] ridx [5] = '{fcb_pkg::IDX_A_TAP6, fcb_pkg::IDX_A_TAP7, fcb_pkg::IDX_A_TAP8,
      fcb_pkg::IDX_A_TAP9, fcb_pkg::IDX_B_TAP1};
   int n_fail = 0;
   int cmp_count = 0;
   logic [31:0] r;
   logic e;

   fcb_coef_bank u_fcb_coef_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_a_tap1_coeff(ca[0][11:0]), .chan_a_tap2_coeff(ca[1][11:0]),
      .chan_a_tap3_coeff(ca[2][11:0]), .chan_a_tap4_coeff(ca[3][11:0]),
      .chan_a_center_coeff(ca[4][17:0]), .chan_b_tap2_coeff(cb[1][11:0]),
      .chan_b_tap3_coeff(cb[2][11:0]), .chan_b_tap4_coeff(cb[3][11:0]),
      .chan_b_center_coeff(cb[4][17:0]), .chan_b_tap6_coeff(cb[5][11:0]),
      .chan_b_tap7_coeff(cb[6][11:0]), .chan_b_tap8_coeff(cb[7][11:0]),
      .chan_b_tap9_coeff(cb[8][11:0]), .chan_a_in_valid(va_in), .chan_a_in_sample(sa_in),
      .chan_b_in_valid(vb_in), .chan_b_in_sample(sb_in), .chan_a_out_data(a_out),
      .chan_a_out_valid(a_ov), .chan_b_out_data(b_out), .chan_b_out_valid(b_ov),
      .single_channel_mode(mode));

   // free-running 100 MHz clock
   initial begin
      forever #5 pclk = ~pclk;
   end

   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; pready is read at the edge, before that edge's updates land
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_fail++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic e_exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
      chk(e, e_exp);
   endtask

   // reserved nibble set on purpose; only bits 11:0 may reach the filter
   function automatic logic [31:0] raw(input int k);
      int c;
      c = (k < 4) ? ca[k + 5] : cb[0];
      return {16'h0, 4'ha, c[11:0]};
   endfunction

   // one sample slot; checks the answer to the previous slot at this edge
   task automatic push(input logic va, input logic vb, input int sa, input int sb);
      va_in <= va;
      vb_in <= vb;
      sa_in <= sa[11:0];
      sb_in <= sb[11:0];
      @(posedge pclk);
      chk(a_ov, pva);
      chk(b_ov, pvb);
      if (pva) chk(64'(signed'(a_out)), pa);
      if (pvb) chk(64'(signed'(b_out)), pb);
      pva = va;
      pvb = vb && !mode_m;
      if (va) begin
         for (int k = 8; k > 0; k--) ha[k] = ha[k - 1];
         ha[0] = sa;
         pa = 0;
         for (int k = 0; k < 9; k++) pa += longint'(ca[k]) * ha[k];
      end
      if (pvb) begin
         for (int k = 8; k > 0; k--) hb[k] = hb[k - 1];
         hb[0] = sb;
         pb = 0;
         for (int k = 0; k < 9; k++) pb += longint'(cb[k]) * hb[k];
      end
   endtask

   task automatic t_reset();
      for (int k = 0; k < 5; k++) rd_chk({ridx[k], 2'b00}, 32'h0, 1'b0);
      rd_chk({fcb_pkg::IDX_CTRL, 2'b00}, 32'h0, 1'b0);
      rd_chk({fcb_pkg::IDX_STATUS, 2'b00}, 32'h0, 1'b0);
   endtask

   task automatic t_regs();
      for (int k = 0; k < 5; k++) apb(1'b1, {ridx[k], 2'b00}, raw(k));
      // lane 0 only: the upper byte with the reserved nibble must keep its value
      pstrb <= 4'h1;
      apb(1'b1, {fcb_pkg::IDX_A_TAP7, 2'b00}, 32'h00005555);
      pstrb <= 4'hf;
      rd_chk({fcb_pkg::IDX_A_TAP7, 2'b00}, 32'h0000a855, 1'b0);
      apb(1'b1, {fcb_pkg::IDX_A_TAP7, 2'b00}, raw(1));
      apb(1'b1, {fcb_pkg::IDX_A_TAP7, 2'b10}, 32'h0);
      chk(e, 1'b1);
      rd_chk(16'h0000, 32'h0, 1'b1);
      for (int k = 0; k < 5; k++) rd_chk({ridx[k], 2'b00}, raw(k), 1'b0);
   endtask

   task automatic t_dual();
      for (int i = 0; i < 10; i++) push(i != 4, 1'b1, (i == 0) ? -2048 : 37 * i - 150, 5 - i);
      push(1'b0, 1'b0, 0, 0);
      ca[8] = 777;
      apb(1'b1, {fcb_pkg::IDX_A_TAP9, 2'b00}, raw(3));
      for (int i = 0; i < 3; i++) push(1'b1, 1'b1, 2047 - i, -i);
      push(1'b0, 1'b0, 0, 0);
      rd_chk({fcb_pkg::IDX_STATUS, 2'b00}, 32'h6, 1'b0);
   endtask

   task automatic t_single();
      apb(1'b1, {fcb_pkg::IDX_CTRL, 2'b00}, 32'h1);
      mode_m = 1'b1;
      chk(mode, 1'b1);
      apb(1'b1, {fcb_pkg::IDX_STATUS, 2'b00}, 32'h0);
      rd_chk({fcb_pkg::IDX_STATUS, 2'b00}, 32'h7, 1'b0);
      for (int i = 0; i < 4; i++) push(1'b1, 1'b1, 100 * i - 99, 999);
      push(1'b0, 1'b0, 0, 0);
      apb(1'b1, {fcb_pkg::IDX_CTRL, 2'b00}, 32'h0);
      mode_m = 1'b0;
      chk(mode, 1'b0);
      for (int i = 0; i < 2; i++) push(1'b0, 1'b1, 0, 7 + i);
      push(1'b0, 1'b0, 0, 0);
   endtask

   // reset held 12 cycles, then the scenarios in order
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_dual();
      t_single();
      summarize();
   end
endmodule
